/* src/rsc_pkg.sv */
// Notes on behaviour
// - Reset output asserts at once when the core regulator drops out of spec.
// - Control bit 6 selects reset output polarity while reset is active.
// - On core recovery a delay runs; reset clears only when it expires.
// - Reset release delay comes from control bits 1:0: 0, 50, 100 or 150 ms.
// - Default control contents give a 100 ms reset release delay.
// - Control bits 5:4 choose which regulators feed power-good.
// - Monitor C, D or E alone, or A, C, D, E together; never B.
// - Control bit 7 selects power-good output polarity.
// - Once monitored outputs are good a delay runs, then power-good asserts.
// - Power-good delay comes from control bits 3:2: 0, 50, 100 or 150 ms.
// - Default power-good delay is 100 ms.
// - Power-up loads defaults; reset output starts with a 100 ms delay.
// - Enable low: shutdown, settings lost; enable high restarts with defaults.
// - Serial traffic is accepted only while enable is high.
// - Reset and power-good outputs do not work while regulator B is off.
// - Strap low or high picks the core regulator default voltage code.
// - Address select pin is the low bit of the slave address.
// - Five 8-bit regulator registers, one control, one on/off register.
// - Each regulator switches and sets its voltage independently.
// - One on/off bit per regulator; 1 on, 0 off, all in one write.
// - Regulator register bit 5: 1 active discharge, 0 load discharge; default 1.
`default_nettype none
package rsc_pkg;
   localparam int REG_COUNT = 5;
   localparam int CODE_W = 5;
   localparam int REG_A = 0;
   localparam int REG_B = 1;
   localparam int REG_C = 2;
   localparam int REG_D = 3;
   localparam int REG_E = 4;
   localparam logic [7:0] ADDR_REG_BASE = 8'h00;
   localparam logic [7:0] ADDR_RSTPG = 8'h05;
   localparam logic [7:0] ADDR_ONOFF = 8'h06;
   localparam logic [5:0] DEV_TYPE_ID = 6'h04;
   localparam int DISCH_BIT = 5;
   localparam int DLY_RST_LSB = 0;
   localparam int DLY_PG_LSB = 2;
   localparam int MON_SEL_LSB = 4;
   localparam int POL_RST_BIT = 6;
   localparam int POL_PG_BIT = 7;
   localparam logic [7:0] RSTPG_DEFAULT = 8'h8A;
   localparam logic [4:0] ONOFF_DEFAULT = 5'h03;
   localparam logic DISCH_DEFAULT = 1'b1;
   localparam logic [7:0] DLY_STEP_MS = 8'h32;
   localparam int MS_NS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      RSC_MON_ACDE,
      RSC_MON_C,
      RSC_MON_D,
      RSC_MON_E
   } rsc_mon_type;

   typedef struct packed {
      logic discharge;
      logic [CODE_W-1:0] code;
   } rsc_setting_type;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } rsc_wr_type;

   // delay code to milliseconds
   function automatic logic [7:0] rsc_delay_ms(input logic [1:0] f);
      logic [7:0] ms;
      ms = 8'h00;
      case (f)
         2'h1: ms = DLY_STEP_MS;
         2'h2: ms = 8'(DLY_STEP_MS << 1);
         2'h3: ms = 8'(DLY_STEP_MS * 8'h03);
         default: ms = 8'h00;
      endcase
      return ms;
   endfunction
endpackage
`default_nettype wire

/* src/rsc_top.sv */
`default_nettype none
module rsc_top #(
   parameter int MS_CYCLES = rsc_pkg::MS_CYCLES_DEFAULT,
   parameter logic [4:0] CORE_CODE_LOW = 5'h00,
   parameter logic [4:0] CORE_CODE_HIGH = 5'h10,
   parameter logic [4:0] OTHER_CODE_DEFAULT = 5'h00
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic address_select_pin,
   input wire logic core_default_strap,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [4:0] reg_in_spec,
   output logic [4:0] reg_on,
   output rsc_pkg::rsc_setting_type [4:0] reg_setting,
   output logic supervisor_reset_out,
   output logic supervisor_reset_oe,
   output logic power_good_out,
   output logic power_good_oe
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);
   localparam logic [PW-1:0] PRE_ONE = PW'(1);

   if (MS_CYCLES < 1) begin : g_chk
      $error("MS_CYCLES must be at least one");
   end

   typedef enum logic [2:0] {
      S_IDLE,
      S_RX,
      S_ACK,
      S_TX,
      S_TXACK
   } rsc_bus_state_type;

   typedef enum logic [1:0] {
      P_ADDR,
      P_PTR,
      P_DATA
   } rsc_phase_type;

   rsc_pkg::rsc_setting_type [4:0] setting_r;
   logic [4:0] onoff_r;
   logic [7:0] rstpg_r;
   logic init_r;
   rsc_pkg::rsc_wr_type wr_r;

   rsc_bus_state_type st_r;
   rsc_phase_type phase_r;
   logic scl_q;
   logic sda_q;
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic rw_r;
   logic nack_r;
   logic [7:0] ptr_r;
   logic drive_low_r;

   logic rst_act_r;
   logic [PW-1:0] rst_pre_r;
   logic [7:0] rst_ms_r;
   logic pg_r;
   logic [PW-1:0] pg_pre_r;
   logic [7:0] pg_ms_r;
   logic sup_out_r;
   logic pg_out_r;
   logic out_ok_r;

   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic core_ok;
   logic mon_ok;
   logic [7:0] rst_tgt;
   logic [7:0] pg_tgt;
   logic [7:0] rd_byte;

   function automatic logic [7:0] read_reg(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a < 8'(rsc_pkg::REG_COUNT)) begin
         d[rsc_pkg::DISCH_BIT] = setting_r[a[2:0]].discharge;
         d[rsc_pkg::CODE_W-1:0] = setting_r[a[2:0]].code;
      end else if (a == rsc_pkg::ADDR_RSTPG) begin
         d = rstpg_r;
      end else if (a == rsc_pkg::ADDR_ONOFF) begin
         d = {3'h0, onoff_r};
      end
      return d;
   endfunction

   always_comb begin
      rd_byte = read_reg(ptr_r);
   end

   // bus line events
   assign start_c = scl && scl_q && sda_q && !sda_i;
   assign stop_c = scl && scl_q && !sda_q && sda_i;
   assign rise_c = scl && !scl_q;
   assign fall_c = !scl && scl_q;
   assign sda_o = 1'b0;
   assign sda_oe = drive_low_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_i;
      end
   end

   // serial slave engine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         phase_r <= P_ADDR;
         sh_r <= 8'h00;
         cnt_r <= 4'h0;
         rw_r <= 1'b0;
         nack_r <= 1'b1;
         ptr_r <= 8'h00;
         drive_low_r <= 1'b0;
         wr_r <= '0;
      end else begin
         wr_r.valid <= 1'b0;
         if (!en || init_r) begin
            st_r <= S_IDLE;
            phase_r <= P_ADDR;
            ptr_r <= 8'h00;
            drive_low_r <= 1'b0;
         end else if (start_c) begin
            st_r <= S_RX;
            phase_r <= P_ADDR;
            cnt_r <= 4'h0;
            drive_low_r <= 1'b0;
         end else if (stop_c) begin
            st_r <= S_IDLE;
            drive_low_r <= 1'b0;
         end else begin
            case (st_r)
               S_RX: begin
                  if (rise_c) begin
                     sh_r <= {sh_r[6:0], sda_i};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (fall_c && cnt_r == 4'h8) begin
                     st_r <= S_ACK;
                     drive_low_r <= 1'b1;
                     if (phase_r == P_ADDR) begin
                        if (sh_r[7:1] == {rsc_pkg::DEV_TYPE_ID, address_select_pin}) begin
                           rw_r <= sh_r[0];
                           phase_r <= P_PTR;
                        end else begin
                           st_r <= S_IDLE;
                           drive_low_r <= 1'b0;
                        end
                     end else if (phase_r == P_PTR) begin
                        ptr_r <= sh_r;
                        phase_r <= P_DATA;
                     end else begin
                        wr_r.valid <= 1'b1;
                        wr_r.addr <= ptr_r;
                        wr_r.data <= sh_r;
                        ptr_r <= ptr_r + 8'h01;
                     end
                  end
               end
               S_ACK: begin
                  if (fall_c) begin
                     cnt_r <= 4'h0;
                     if (rw_r && phase_r == P_PTR) begin
                        st_r <= S_TX;
                        sh_r <= rd_byte;
                        ptr_r <= ptr_r + 8'h01;
                        drive_low_r <= !rd_byte[7];
                     end else begin
                        st_r <= S_RX;
                        drive_low_r <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (fall_c) begin
                     if (cnt_r == 4'h7) begin
                        st_r <= S_TXACK;
                        drive_low_r <= 1'b0;
                     end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        drive_low_r <= !sh_r[6];
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               S_TXACK: begin
                  if (rise_c) begin
                     nack_r <= sda_i;
                  end else if (fall_c) begin
                     if (nack_r) begin
                        st_r <= S_IDLE;
                     end else begin
                        st_r <= S_TX;
                        cnt_r <= 4'h0;
                        sh_r <= rd_byte;
                        ptr_r <= ptr_r + 8'h01;
                        drive_low_r <= !rd_byte[7];
                     end
                  end
               end
               default: begin
                  drive_low_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // defaults reload on every enable rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_r <= 1'b1;
      end else begin
         init_r <= !en;
      end
   end

   // register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < rsc_pkg::REG_COUNT; i++) begin
            setting_r[i] <= '0;
         end
         onoff_r <= 5'h00;
         rstpg_r <= 8'h00;
      end else if (init_r) begin
         for (int i = 0; i < rsc_pkg::REG_COUNT; i++) begin
            setting_r[i].discharge <= rsc_pkg::DISCH_DEFAULT;
            setting_r[i].code <= OTHER_CODE_DEFAULT;
         end
         setting_r[rsc_pkg::REG_A].code <= core_default_strap ? CORE_CODE_HIGH : CORE_CODE_LOW;
         onoff_r <= rsc_pkg::ONOFF_DEFAULT;
         rstpg_r <= rsc_pkg::RSTPG_DEFAULT;
      end else if (wr_r.valid) begin
         if (wr_r.addr < 8'(rsc_pkg::REG_COUNT)) begin
            setting_r[wr_r.addr[2:0]].discharge <= wr_r.data[rsc_pkg::DISCH_BIT];
            setting_r[wr_r.addr[2:0]].code <= wr_r.data[rsc_pkg::CODE_W-1:0];
         end else if (wr_r.addr == rsc_pkg::ADDR_RSTPG) begin
            rstpg_r <= wr_r.data;
         end else if (wr_r.addr == rsc_pkg::ADDR_ONOFF) begin
            onoff_r <= wr_r.data[4:0];
         end
      end
   end

   assign reg_setting = setting_r;
   assign reg_on = en ? onoff_r : 5'h00;

   assign core_ok = reg_in_spec[rsc_pkg::REG_A];
   assign rst_tgt = rsc_pkg::rsc_delay_ms(rstpg_r[rsc_pkg::DLY_RST_LSB +: 2]);
   assign pg_tgt = rsc_pkg::rsc_delay_ms(rstpg_r[rsc_pkg::DLY_PG_LSB +: 2]);

   always_comb begin
      case (rsc_pkg::rsc_mon_type'(rstpg_r[rsc_pkg::MON_SEL_LSB +: 2]))
         rsc_pkg::RSC_MON_C: mon_ok = reg_in_spec[rsc_pkg::REG_C];
         rsc_pkg::RSC_MON_D: mon_ok = reg_in_spec[rsc_pkg::REG_D];
         rsc_pkg::RSC_MON_E: mon_ok = reg_in_spec[rsc_pkg::REG_E];
         default: mon_ok = reg_in_spec[rsc_pkg::REG_A] && reg_in_spec[rsc_pkg::REG_C]
                        && reg_in_spec[rsc_pkg::REG_D] && reg_in_spec[rsc_pkg::REG_E];
      endcase
   end

   // reset supervisor
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_act_r <= 1'b1;
         rst_pre_r <= '0;
         rst_ms_r <= 8'h00;
      end else if (init_r) begin
         rst_act_r <= 1'b1;
         rst_pre_r <= '0;
         rst_ms_r <= 8'h00;
      end else if (!core_ok) begin
         rst_act_r <= 1'b1;
         rst_pre_r <= '0;
         rst_ms_r <= 8'h00;
      end else if (rst_act_r) begin
         if (rst_ms_r >= rst_tgt) begin
            rst_act_r <= 1'b0;
         end else if (rst_pre_r == PRE_LAST) begin
            rst_pre_r <= '0;
            rst_ms_r <= rst_ms_r + 8'h01;
         end else begin
            rst_pre_r <= rst_pre_r + PRE_ONE;
         end
      end
   end

   // power-good supervisor
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_r <= 1'b0;
         pg_pre_r <= '0;
         pg_ms_r <= 8'h00;
      end else if (init_r || !mon_ok) begin
         pg_r <= 1'b0;
         pg_pre_r <= '0;
         pg_ms_r <= 8'h00;
      end else if (!pg_r) begin
         // assert after delay, default 100 ms
         if (pg_ms_r >= pg_tgt) begin
            pg_r <= 1'b1;
         end else if (pg_pre_r == PRE_LAST) begin
            pg_pre_r <= '0;
            pg_ms_r <= pg_ms_r + 8'h01;
         end else begin
            pg_pre_r <= pg_pre_r + PRE_ONE;
         end
      end
   end

   // output pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sup_out_r <= 1'b0;
         pg_out_r <= 1'b0;
         out_ok_r <= 1'b0;
      end else begin
         // dead while B off, dead while disabled
         out_ok_r <= en && !init_r && onoff_r[rsc_pkg::REG_B];
         sup_out_r <= rstpg_r[rsc_pkg::POL_RST_BIT] ? rst_act_r : !rst_act_r;
         pg_out_r <= rstpg_r[rsc_pkg::POL_PG_BIT] ? pg_r : !pg_r;
      end
   end

   assign supervisor_reset_out = out_ok_r && sup_out_r;
   assign supervisor_reset_oe = out_ok_r;
   assign power_good_out = out_ok_r && pg_out_r;
   assign power_good_oe = out_ok_r;
endmodule
`default_nettype wire

/* tb/rsc_top_asserts.sv */
`default_nettype none
module rsc_top_asserts #(
   parameter int MS_CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic address_select_pin,
   input wire logic core_default_strap,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic [4:0] reg_in_spec,
   input wire logic [4:0] reg_on,
   input wire rsc_pkg::rsc_setting_type [4:0] reg_setting,
   input wire logic supervisor_reset_out,
   input wire logic supervisor_reset_oe,
   input wire logic power_good_out,
   input wire logic power_good_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence off_run;
      !en [*3];
   endsequence
   sequence core_bad_run;
      (supervisor_reset_oe && !reg_in_spec[rsc_pkg::REG_A]) [*4];
   endsequence
   oe_gates_out_a: assert property (!supervisor_reset_oe |-> !supervisor_reset_out && !power_good_out)
      else $error("output driven while not functional");
   oe_pair_a: assert property (power_good_oe == supervisor_reset_oe)
      else $error("output enables differ");
   b_off_dead_a: assert property (!reg_on[rsc_pkg::REG_B] |=> !supervisor_reset_oe && !power_good_oe)
      else $error("outputs enabled while io regulator off");
   off_no_oe_a: assert property (off_run |-> !supervisor_reset_oe && !power_good_oe)
      else $error("outputs enabled while disabled");
   off_regs_off_a: assert property (off_run |-> reg_on == 5'h00)
      else $error("regulator on while disabled");
   off_no_ack_a: assert property (off_run |-> !sda_oe)
      else $error("serial answer while disabled");
   sda_open_drain_a: assert property (sda_o == 1'b0)
      else $error("serial data driven high");
   core_hold_a: assert property (core_bad_run |-> $stable(supervisor_reset_out))
      else $error("reset released while core bad");
   pg_hold_a: assert property ((power_good_oe && reg_in_spec[4:2] == 3'h0) [*4] |-> $stable(power_good_out))
      else $error("power good moved while monitored set bad");
   defaults_load_a: assert property ($rose(en) |-> ##3 (reg_setting[0].discharge && reg_on == 5'h03))
      else $error("defaults not loaded on enable");
endmodule
bind rsc_top rsc_top_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.*);
`default_nettype wire

/* tb/rsc_host.sv */
`default_nettype none
module rsc_host (
   input wire logic clk,
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic gap();
      repeat (4) @(posedge clk);
   endtask
   task automatic start();
      gap();
      sda_low <= 1'b0;
      gap();
      scl <= 1'b1;
      gap();
      sda_low <= 1'b1;
      gap();
      scl <= 1'b0;
   endtask
   task automatic stop();
      gap();
      sda_low <= 1'b1;
      gap();
      scl <= 1'b1;
      gap();
      sda_low <= 1'b0;
      gap();
   endtask
   // nine bits msb first, the last one is the acknowledge slot
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         gap();
         sda_low <= !d[i];
         gap();
         scl <= 1'b1;
         gap();
         q[i] = sda;
         gap();
         scl <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* tb/tb_regulator_supervisor_control.sv */
`default_nettype none
module tb_regulator_supervisor_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, en = 1'b0, a0 = 1'b0, strap = 1'b0, dv = 1'b0;
   logic [4:0] spec = 5'h1F;
   logic scl, host_low, sda, sda_o, sda_oe, rst_out, rst_oe, pg_out, pg_oe;
   logic [4:0] reg_on;
   logic [7:0] rd_v;
   rsc_pkg::rsc_setting_type [4:0] setting;
   int err_count = 0, total_checks = 0, cycles = 0;
   always #5 clk = ~clk;
   // pull-up: low while either party pulls
   assign sda = !(sda_oe || host_low);
   rsc_top #(.MS_CYCLES(10)) i_dut (.clk(clk), .rst(rst), .en(en), .address_select_pin(a0),
      .core_default_strap(strap), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .reg_in_spec(spec),
      .reg_on(reg_on), .reg_setting(setting), .supervisor_reset_out(rst_out), .supervisor_reset_oe(rst_oe),
      .power_good_out(pg_out), .power_good_oe(pg_oe));
   rsc_host i_host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put(input logic [7:0] b, input logic ack);
      logic [8:0] q;
      i_host.xfer({b, 1'b1}, q);
      chk(8'(!q[0]), 8'(ack));
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic ack);
      i_host.start();
      put({6'h04, dv, 1'b0}, ack);
      put(p, ack);
      put(d, ack);
      i_host.stop();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [8:0] q;
      i_host.start();
      put({6'h04, dv, 1'b0}, 1'b1);
      put(p, 1'b1);
      i_host.start();
      put({6'h04, dv, 1'b1}, 1'b1);
      i_host.xfer(9'h1FF, q);
      d = q[8:1];
      i_host.stop();
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      tick(8);
      rst <= 1'b0;
      en <= 1'b1;
      tick(4);
      @(negedge clk);
      chk(8'({rst_oe, rst_out, pg_out}), 8'h04);
      tick(980);
      @(negedge clk);
      chk(8'({rst_out, pg_out}), 8'h00);
      tick(30);
      @(negedge clk);
      chk(8'({rst_out, pg_out}), 8'h03);
      rd(8'h05, rd_v);
      chk(rd_v, rsc_pkg::RSTPG_DEFAULT);
      chk(8'(reg_on), 8'h03);
      chk(8'(setting[0]), 8'h20);
      $display("defaults end");
      for (int r = 0; r < 5; r++) begin
         wr(8'(r), 8'hC0 | 8'(8'h0D * r), 1'b1);
      end
      wr(8'h07, 8'hFF, 1'b1);
      for (int r = 0; r < 8; r++) begin
         rd(8'(r), rd_v);
         if (r < 5) begin
            chk(rd_v, 8'(8'h0D * r));
            chk(8'(setting[r]), 8'(8'h0D * r));
         end else if (r == 7) begin
            chk(rd_v, 8'h00);
         end
      end
      wr(8'h06, 8'h1D, 1'b1);
      chk(8'({rst_oe, pg_oe, rst_out, pg_out}), 8'h00);
      chk(8'(reg_on), 8'h1D);
      wr(8'h06, 8'h1F, 1'b1);
      chk(8'(reg_on), 8'h1F);
      $display("registers end");
      for (int c = 0; c < 4; c++) begin
         wr(8'h05, 8'hC0 | 8'(c * 5), 1'b1);
         tick(1);
         spec <= 5'h1E;
         tick(3);
         @(negedge clk);
         chk(8'({rst_out, pg_out}), 8'h02);
         tick(1);
         spec <= 5'h1F;
         if (c > 0) begin
            tick(c * 500 - 2);
            @(negedge clk);
            chk(8'({rst_out, pg_out}), 8'h02);
         end
         tick(8);
         @(negedge clk);
         chk(8'({rst_out, pg_out}), 8'h01);
      end
      $display("delays end");
      wr(8'h05, 8'h00, 1'b1);
      tick(4);
      @(negedge clk);
      chk(8'({rst_out, pg_out}), 8'h02);
      tick(1);
      spec <= 5'h00;
      tick(5);
      @(negedge clk);
      chk(8'({rst_out, pg_out}), 8'h01);
      tick(1);
      spec <= 5'h1F;
      for (int s = 0; s < 4; s++) begin
         wr(8'h05, 8'hC0 | 8'(s << 4), 1'b1);
         tick(1);
         spec <= (s == 0) ? 5'h1D : 5'h1C;
         tick(5);
         @(negedge clk);
         chk(8'(pg_out), 8'h01);
         tick(1);
         spec <= (s == 0) ? 5'h1B : ~(5'h02 << s);
         tick(5);
         @(negedge clk);
         chk(8'(pg_out), 8'h00);
         tick(1);
         spec <= 5'h1F;
      end
      $display("monitor end");
      en <= 1'b0;
      strap <= 1'b1;
      tick(4);
      wr(8'h05, 8'h00, 1'b0);
      chk(8'(reg_on), 8'h00);
      tick(1);
      en <= 1'b1;
      tick(4);
      rd(8'h05, rd_v);
      chk(rd_v, rsc_pkg::RSTPG_DEFAULT);
      chk(8'(setting[0]), 8'h30);
      dv = 1'b1;
      wr(8'h05, 8'h00, 1'b0);
      tick(1);
      a0 <= 1'b1;
      tick(2);
      wr(8'h05, 8'h4F, 1'b1);
      rd(8'h05, rd_v);
      chk(rd_v, 8'h4F);
      $display("enable end");
      conclude();
   end
endmodule
`default_nettype wire
